// ---- ccl_pkg.sv ----
// constants and types shared by the counter, compare and latch block
package ccl_pkg;

  // channel count and widths
  localparam int NCH = 4;
  localparam int CNT_W = 32;
  localparam int NPWM = 8;

  // register offsets (byte addresses; count, compare and latch are four-word windows, pwm duty eight words)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_PERIOD = 8'h10;
  localparam logic [7:0] OFS_TS = 8'h14;
  localparam logic [7:0] OFS_PWM_PER = 8'h18;
  localparam logic [7:0] OFS_CNT = 8'h20;
  localparam logic [7:0] OFS_CMP = 8'h30;
  localparam logic [7:0] OFS_LATCH = 8'h40;
  localparam logic [7:0] OFS_PWM_DUTY = 8'h60;

  // trigger source field codes
  localparam logic [1:0] SRC_TRIG = 2'h0;
  localparam logic [1:0] SRC_SYNC = 2'h1;
  localparam logic [1:0] SRC_TIMER = 2'h2;

  // edge evaluation codes, two bits per channel
  localparam logic [1:0] EDGE_SINGLE = 2'h0;
  localparam logic [1:0] EDGE_DOUBLE = 2'h1;
  localparam logic [1:0] EDGE_QUAD = 2'h2;

  // status and mask bit positions
  localparam int ST_CAP = 0;
  localparam int ST_CMP = 1;
  localparam int ST_SEQ = 2;
  localparam int ST_W = 3;

  // reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [7:0] EDGE_RST = 8'hAA;
  localparam logic [31:0] PERIOD_RST = 32'h0000_0000;

  // time stamp tick of one microsecond
  localparam int CLK_HZ = 25_000_000;
  localparam int TS_TICK_NS = 1000;
  localparam int TS_DIV = (TS_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;

  // control register layout
  typedef struct packed {
    logic [3:0] cmp_en;
    logic spare;
    logic idx_clr;
    logic modulo;
    logic [1:0] src;
    logic acq_en;
    logic init_done;
    logic pwm_mode;
  } ccl_ctrl_t;

  // one captured set: time stamp plus all counts
  typedef struct packed {
    logic [31:0] ts;
    logic [NCH-1:0][CNT_W-1:0] cnt;
  } ccl_cap_t;

  // acquisition state
  typedef enum logic [0:0] {ACQ_IDLE, ACQ_RUN} ccl_acq_t;

endpackage

// ---- ccl_top.sv ----
// four channel quadrature counter with compare, latch and acquisition
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps

// How it works
// - four channels, each a 32-bit count
// - single, double or quadruple edge evaluation
// - inputs become eight pwm outputs, config-fixed
// - count equals compare raises trigger, latches
// - modulo mode retriggers at each multiple
// - compare trigger driven onto sync output
// - each count, compare or latch read returns one channel
// - capture on trigger input or sync trigger
// - periodic capture paced by internal timer
// - captured sets pushed out without request
// - each capture carries a time stamp
module ccl_top #(
  parameter int PWM_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ccl_pkg::NCH-1:0] enc_a,
  input wire logic [ccl_pkg::NCH-1:0] enc_b,
  input wire logic [ccl_pkg::NCH-1:0] enc_idx,
  input wire logic trig_in,
  input wire logic sync_in,
  output logic sync_out,
  output logic [ccl_pkg::NPWM-1:0] pwm_out,
  output logic cap_valid,
  output ccl_pkg::ccl_cap_t cap_data,
  output logic irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import ccl_pkg::*;

  ccl_ctrl_t ctrl_reg;
  ccl_acq_t acq_reg;
  logic [2*NCH-1:0] edge_reg;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] stat_set;
  logic [31:0] period_reg;
  logic [31:0] tmr_reg;
  logic [31:0] ts_reg;
  logic [7:0] tsdiv_reg;
  logic [NCH-1:0][CNT_W-1:0] cnt_reg;
  logic [NCH-1:0][CNT_W-1:0] cmp_reg;
  logic [NCH-1:0][CNT_W-1:0] tgt_reg;
  logic [NCH-1:0][CNT_W-1:0] latch_reg;
  logic [NCH-1:0][CNT_W-1:0] cnt_next;
  logic [NCH-1:0] a_reg;
  logic [NCH-1:0] b_reg;
  logic [NCH-1:0] idx_reg;
  logic [NCH-1:0] step;
  logic [NCH-1:0] up;
  logic [NCH-1:0] match;
  logic [NCH-1:0] wr_cmp;
  logic [NPWM-1:0][PWM_W-1:0] duty_reg;
  logic [PWM_W-1:0] pwm_per_reg;
  logic [PWM_W-1:0] pwm_cnt_reg;
  logic trig_prev_reg;
  logic sync_prev_reg;
  logic counting;
  logic cmp_trig;
  logic timer_tick;
  logic acq_fire;
  logic [31:0] rd_mux;

  // counters only run once inputs are initialised and not in pwm mode
  // init before counting
  assign counting = ctrl_reg.init_done & ~ctrl_reg.pwm_mode;

  // per channel decode and compare
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      logic a_edge;
      logic b_edge;
      assign a_edge = enc_a[gi] ^ a_reg[gi];
      assign b_edge = enc_b[gi] ^ b_reg[gi];

      always_comb
      begin
        step[gi] = 1'b0;
        up[gi] = 1'b0;
        case (edge_reg[2*gi +: 2])
          EDGE_SINGLE:
          begin
            step[gi] = a_edge & enc_a[gi];
            up[gi] = ~enc_b[gi];
          end
          EDGE_DOUBLE:
          begin
            step[gi] = a_edge;
            up[gi] = enc_a[gi] ^ enc_b[gi];
          end
          default:
          begin
            // quad: a edge counts like double, b edge the inverse sense
            step[gi] = a_edge | b_edge;
            up[gi] = a_edge ? (enc_a[gi] ^ enc_b[gi])
                            : ~(enc_a[gi] ^ enc_b[gi]);
          end
        endcase
      end

      assign cnt_next[gi] = up[gi] ? cnt_reg[gi] + 32'h0000_0001
                                   : cnt_reg[gi] - 32'h0000_0001;

      assign match[gi] = counting & step[gi] & ctrl_reg.cmp_en[gi] &
                         (cnt_next[gi] == tgt_reg[gi]);

      assign wr_cmp[gi] = reg_wr & (reg_addr[7:4] == OFS_CMP[7:4]) &
                          (reg_addr[3:2] == 2'(gi));

      // count register, index may zero it
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          cnt_reg[gi] <= 32'h0000_0000;
        else if (counting & ctrl_reg.idx_clr & enc_idx[gi] & ~idx_reg[gi])
          cnt_reg[gi] <= 32'h0000_0000;
        else if (counting & step[gi])
          cnt_reg[gi] <= cnt_next[gi];
      end

      // compare value and moving target
      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
        begin
          cmp_reg[gi] <= 32'h0000_0000;
          tgt_reg[gi] <= 32'h0000_0000;
        end
        else if (wr_cmp[gi])
        begin
          cmp_reg[gi] <= reg_wdata;
          tgt_reg[gi] <= reg_wdata;
        end
        // next multiple in the running direction
        else if (match[gi] & ctrl_reg.modulo)
          tgt_reg[gi] <= up[gi] ? tgt_reg[gi] + cmp_reg[gi]
                                : tgt_reg[gi] - cmp_reg[gi];
      end

      always_ff @(posedge sys_clk or posedge rst)
      begin
        if (rst)
          latch_reg[gi] <= 32'h0000_0000;
        else if (match[gi])
          latch_reg[gi] <= cnt_next[gi];
      end
    end
  endgenerate

  // previous input levels for edge detection
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      a_reg <= '0;
      b_reg <= '0;
      idx_reg <= '0;
      trig_prev_reg <= 1'b0;
      sync_prev_reg <= 1'b0;
    end
    else
    begin
      a_reg <= enc_a;
      b_reg <= enc_b;
      idx_reg <= enc_idx;
      trig_prev_reg <= trig_in;
      sync_prev_reg <= sync_in;
    end
  end

  // any channel match is the block's own synchro trigger
  assign cmp_trig = |match;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sync_out <= 1'b0;
    else
      sync_out <= cmp_trig;
  end

  // free running microsecond time stamp
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      tsdiv_reg <= 8'h00;
      ts_reg <= 32'h0000_0000;
    end
    else if (tsdiv_reg == 8'(TS_DIV - 1))
    begin
      tsdiv_reg <= 8'h00;
      ts_reg <= ts_reg + 32'h0000_0001;
    end
    else
      tsdiv_reg <= tsdiv_reg + 8'h01;
  end

  // synchro timer, period zero stops it
  // at-or-above so a shortened period cannot strand the timer past its end
  assign timer_tick = (period_reg != 32'h0000_0000) &&
                      (tmr_reg >= period_reg - 32'h0000_0001);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tmr_reg <= 32'h0000_0000;
    else if (acq_reg != ACQ_RUN || timer_tick ||
             period_reg == 32'h0000_0000)
      tmr_reg <= 32'h0000_0000;
    else
      tmr_reg <= tmr_reg + 32'h0000_0001;
  end

  // acquisition state: runs only when enabled after initialisation
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      acq_reg <= ACQ_IDLE;
    else
      case (acq_reg)
        ACQ_IDLE:
          if (ctrl_reg.acq_en & counting)
            acq_reg <= ACQ_RUN;
        ACQ_RUN:
          if (~ctrl_reg.acq_en | ~counting)
            acq_reg <= ACQ_IDLE;
        default:
          acq_reg <= ACQ_IDLE;
      endcase
  end

  always_comb
  begin
    acq_fire = 1'b0;
    case (ctrl_reg.src)
      SRC_TRIG:
        acq_fire = trig_in & ~trig_prev_reg;
      SRC_SYNC:
        acq_fire = (sync_in & ~sync_prev_reg) | cmp_trig;
      SRC_TIMER:
        acq_fire = timer_tick;
      default:
        acq_fire = 1'b0;
    endcase
    if (acq_reg != ACQ_RUN)
      acq_fire = 1'b0;
  end

  // push captured set out at once
  // stamp taken in the capture cycle
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cap_valid <= 1'b0;
      cap_data <= '0;
    end
    else
    begin
      cap_valid <= acq_fire;
      if (acq_fire)
      begin
        cap_data.ts <= ts_reg;
        cap_data.cnt <= cnt_reg;
      end
    end
  end

  // pwm period counter, outputs low outside pwm mode
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pwm_cnt_reg <= '0;
    else if (~ctrl_reg.pwm_mode || pwm_cnt_reg >= pwm_per_reg)
      pwm_cnt_reg <= '0;
    else
      pwm_cnt_reg <= pwm_cnt_reg + PWM_W'(1);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      pwm_out <= '0;
    else
      for (int k = 0; k < NPWM; k++)
        pwm_out[k] <= ctrl_reg.pwm_mode & (pwm_cnt_reg < duty_reg[k]);
  end

  // events for status; sequence error when acquisition asked before init
  assign stat_set[ST_CAP] = acq_fire;
  assign stat_set[ST_CMP] = cmp_trig;
  assign stat_set[ST_SEQ] = ctrl_reg.acq_en & ~ctrl_reg.init_done;

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      stat_reg <= '0;
    else if (reg_wr && reg_addr == OFS_STAT)
      stat_reg <= (stat_reg & ~reg_wdata[ST_W-1:0]) | stat_set;
    else
      stat_reg <= stat_reg | stat_set;
  end

  assign irq = |(stat_reg & mask_reg);

  // configuration registers
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= CTRL_RST;
      edge_reg <= EDGE_RST;
      mask_reg <= '0;
      period_reg <= PERIOD_RST;
      pwm_per_reg <= '0;
    end
    else if (reg_wr)
      case (reg_addr)
        OFS_CTRL:
        begin
          ctrl_reg <= reg_wdata[11:0];
          if (ctrl_reg.init_done)
            ctrl_reg.pwm_mode <= ctrl_reg.pwm_mode;
        end
        OFS_EDGE: edge_reg <= reg_wdata[2*NCH-1:0];
        OFS_MASK: mask_reg <= reg_wdata[ST_W-1:0];
        OFS_PERIOD: period_reg <= reg_wdata;
        OFS_PWM_PER: pwm_per_reg <= reg_wdata[PWM_W-1:0];
        default: ;
      endcase
  end

  // pwm duty words, eight in a row
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      duty_reg <= '0;
    else if (reg_wr && reg_addr[7:5] == OFS_PWM_DUTY[7:5])
      duty_reg[reg_addr[4:2]] <= reg_wdata[PWM_W-1:0];
  end

  // read mux; count and latch windows hold one channel per word
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (reg_addr[7:4])
      OFS_CTRL[7:4]:
        case (reg_addr)
          OFS_CTRL: rd_mux = 32'(ctrl_reg);
          OFS_EDGE: rd_mux = 32'(edge_reg);
          OFS_STAT: rd_mux = 32'(stat_reg);
          OFS_MASK: rd_mux = 32'(mask_reg);
          default: rd_mux = 32'h0000_0000;
        endcase
      OFS_PERIOD[7:4]:
        case (reg_addr)
          OFS_PERIOD: rd_mux = period_reg;
          OFS_TS: rd_mux = ts_reg;
          OFS_PWM_PER: rd_mux = 32'(pwm_per_reg);
          default: rd_mux = {31'h0000_0000, acq_reg == ACQ_RUN};
        endcase
      OFS_CNT[7:4]: rd_mux = cnt_reg[reg_addr[3:2]];
      OFS_CMP[7:4]: rd_mux = cmp_reg[reg_addr[3:2]];
      OFS_LATCH[7:4]: rd_mux = latch_reg[reg_addr[3:2]];
      OFS_PWM_DUTY[7:4], 4'h7:
        rd_mux = 32'(duty_reg[reg_addr[4:2]]);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 32'h0000_0000;
  end

endmodule // ccl_top

// ---- ccl_props.sv ----
// port checker for the counter, compare and latch block
`timescale 1ns/1ps
module ccl_props
  import ccl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ccl_pkg::NCH-1:0] enc_a,
  input wire logic [ccl_pkg::NCH-1:0] enc_b,
  input wire logic [ccl_pkg::NCH-1:0] enc_idx,
  input wire logic trig_in,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic [ccl_pkg::NPWM-1:0] pwm_out,
  input wire logic cap_valid,
  input wire ccl_pkg::ccl_cap_t cap_data,
  input wire logic irq,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  logic [2:0] mask_q;
  logic [2:0] ctl_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of mask and control; mode bit locked once inputs are set up
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mask_q <= 3'h0;
      ctl_q <= 3'h0;
    end
    else if (reg_wr && reg_addr == OFS_MASK)
      mask_q <= reg_wdata[2:0];
    else if (reg_wr && reg_addr == OFS_CTRL)
      ctl_q <= {reg_wdata[2:1], ctl_q[1] ? ctl_q[0] : reg_wdata[0]};
  end
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not idle");
  chk_unmapped_zero: assert property (reg_rd && reg_addr == 8'hFC |=>
    reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  chk_mask_read: assert property (reg_rd && reg_addr == OFS_MASK |=>
    reg_rdata == {29'h0, mask_q})
    else $error("mask read back wrong");
  chk_mask_quiet: assert property (mask_q == 3'h0 |-> !irq)
    else $error("irq while all masked");
  chk_cap_irq: assert property (cap_valid && mask_q[ST_CAP] |-> irq)
    else $error("capture did not raise irq");
  chk_cmp_irq: assert property (sync_out && mask_q[ST_CMP] |-> irq)
    else $error("compare did not raise irq");
  chk_cap_hold: assert property (!cap_valid |-> $stable(cap_data))
    else $error("capture data moved without valid");
  chk_no_cap_idle: assert property (!ctl_q[2] && !$past(ctl_q[2]) &&
    !$past(ctl_q[2], 2) |-> !cap_valid)
    else $error("capture while acquisition off");
  chk_pwm_idle: assert property (!ctl_q[0] && !$past(ctl_q[0]) &&
    !$past(ctl_q[0], 2) |-> pwm_out == 8'h00)
    else $error("pwm active in counter mode");
  cover property (cap_valid);
  cover property (sync_out);
  cover property (irq ##1 !irq);
endmodule // ccl_props

bind ccl_top ccl_props i_ccl_props (.sys_clk(sys_clk), .rst(rst),
  .enc_a(enc_a), .enc_b(enc_b), .enc_idx(enc_idx), .trig_in(trig_in),
  .sync_in(sync_in), .sync_out(sync_out), .pwm_out(pwm_out),
  .cap_valid(cap_valid), .cap_data(cap_data), .irq(irq),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// ---- ccl_enc_model.sv ----
// quadrature encoder model driving the phase lines
`timescale 1ns/1ps
module ccl_enc_model
  import ccl_pkg::*;
(
  input wire logic sys_clk,
  output logic [ccl_pkg::NCH-1:0] enc_a,
  output logic [ccl_pkg::NCH-1:0] enc_b,
  output logic [ccl_pkg::NCH-1:0] enc_idx
);
  logic [1:0] ph [NCH];
  initial
    for (int i = 0; i < NCH; i++)
      ph[i] = 2'h0;
  // phase A leads B going up
  always_comb
    for (int i = 0; i < NCH; i++)
    begin
      enc_a[i] = ph[i][0] ^ ph[i][1];
      enc_b[i] = ph[i][1];
      enc_idx[i] = 1'b0; // index left quiet, clearing is not exercised
    end
  // n quarter steps per call, gap of idle cycles after each makes it slow
  task automatic move(input int ch, input int n, input bit up, input int gap);
    repeat (n)
    begin
      @(posedge sys_clk);
      ph[ch] <= up ? ph[ch] + 2'h1 : ph[ch] - 2'h1;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
endmodule // ccl_enc_model

// ---- tb.sv ----
// self-checking bench for the counter, compare and latch block
`timescale 1ns/1ps
module tb;
  import ccl_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, trig_in = 1'b0, sync_in = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, sync_out, cap_valid, irq, up;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d, ts0;
  logic [NCH-1:0] enc_a, enc_b, enc_idx;
  logic [NPWM-1:0] pwm_out;
  ccl_cap_t cap_data;
  logic [31:0] exp_cnt [NCH];
  int err_total = 0, checks_done = 0, sync_cnt = 0, n;
  ccl_top i_ccl_top (.sys_clk(sys_clk), .rst(rst), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx(enc_idx), .trig_in(trig_in), .sync_in(sync_in),
    .sync_out(sync_out), .pwm_out(pwm_out), .cap_valid(cap_valid),
    .cap_data(cap_data), .irq(irq), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  ccl_enc_model i_ccl_enc_model (.sys_clk(sys_clk), .enc_a(enc_a),
    .enc_b(enc_b), .enc_idx(enc_idx));
  initial forever #20 sys_clk = ~sys_clk;
  // tally of trigger pulses seen on the sync output
  always @(posedge sys_clk) if (sync_out === 1'b1) sync_cnt <= sync_cnt + 1;
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // strobe dropped one edge later, so back to back calls never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string w);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    // read data stand only in this cycle, so look once it has settled
    #1 chk(w, reg_rdata, e);
    @(posedge sys_clk);
  endtask
  // bounded wait for a capture pulse, cycles counted from the call
  task automatic wait_cap(output int cyc);
    cyc = 0;
    do
    begin
      @(posedge sys_clk);
      #1 cyc++;
    end while (cap_valid !== 1'b1 && cyc < 400);
    if (cyc >= 400)
    begin
      err_total++;
      give_verdict();
    end
  endtask
  function automatic int per_turn(input int m);
    return m == EDGE_SINGLE ? 1 : m == EDGE_DOUBLE ? 2 : 4;
  endfunction
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hB9B9));
    for (int i = 0; i < NCH; i++)
      exp_cnt[i] = 32'h0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc(OFS_EDGE, 32'hAA, "edge reset");
    rdc(OFS_CTRL, 32'h0, "ctrl reset");
    rdc(8'hFC, 32'h0, "unmapped");
    $display("test reset done");
    // modulo compare on channel 0 in quad mode: matches at 4, 8, 12
    wr(OFS_MASK, 32'h7);
    rdc(OFS_MASK, 32'h7, "mask");
    wr(OFS_CMP, 32'h4);
    wr(OFS_CTRL, 32'h122);
    i_ccl_enc_model.move(0, 12, 1'b1, 1);
    repeat (3) @(posedge sys_clk);
    chk("sync pulses", sync_cnt, 32'h3);
    rdc(OFS_LATCH, 32'hC, "latch");
    exp_cnt[0] = 32'hC;
    rdc(OFS_STAT, 32'h2, "cmp status");
    chk("irq raised", irq, 1'b1);
    wr(OFS_STAT, 32'h7);
    #1 chk("irq cleared", irq, 1'b0);
    $display("test compare done");
    // each edge mode, random moves of every channel both ways
    wr(OFS_CTRL, 32'h2);
    for (int m = 0; m < 3; m++)
    begin
      wr(OFS_EDGE, {24'h0, {4{2'(m)}}});
      for (int ch = 0; ch < NCH; ch++)
      begin
        n = 1 + $urandom_range(5);
        up = 1'($urandom_range(1));
        i_ccl_enc_model.move(ch, 4 * n, up, $urandom_range(2));
        d = 32'(n * per_turn(m));
        exp_cnt[ch] = up ? exp_cnt[ch] + d : exp_cnt[ch] - d;
        @(posedge sys_clk);
        rdc(OFS_CNT + 8'(4 * ch), exp_cnt[ch], "count");
      end
    end
    $display("test counting done");
    // setup out of order is refused and flagged
    wr(OFS_CTRL, 32'h4);
    rdc(8'h1C, 32'h0, "not running");
    rdc(OFS_STAT, 32'h4, "order error");
    wr(OFS_CTRL, 32'h2);
    wr(OFS_STAT, 32'h7);
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_CTRL, 32'h6 | (s << 3));
      repeat (1 + $urandom_range(3)) @(posedge sys_clk);
      if (s == 0)
        trig_in <= 1'b1;
      else
        sync_in <= 1'b1;
      wait_cap(n);
      chk("cap latency", n, 32'h1);
      for (int ch = 0; ch < NCH; ch++)
        chk("cap count", cap_data.cnt[ch], exp_cnt[ch]);
      trig_in <= 1'b0;
      sync_in <= 1'b0;
    end
    // periodic capture every 50 cycles, 2 us of stamp apart
    wr(OFS_PERIOD, 32'h32);
    wr(OFS_CTRL, 32'h16);
    wait_cap(n);
    ts0 = cap_data.ts;
    wait_cap(n);
    chk("timer gap", n, 32'h32);
    chk("stamp gap", cap_data.ts - ts0, 32'h2);
    wr(OFS_MASK, 32'h0);
    #1 chk("irq masked", irq, 1'b0);
    $display("test acquisition done");
    // pulse outputs: duty 3 of a 10 cycle period
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PWM_DUTY, 32'h3);
    wr(OFS_PWM_PER, 32'h9);
    wr(OFS_CTRL, 32'h1);
    repeat (4) @(posedge sys_clk);
    n = 0;
    repeat (100) @(posedge sys_clk) n += (pwm_out[0] === 1'b1);
    chk("pwm high", n, 32'h1E);
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CTRL, 32'h2);
    rdc(OFS_CTRL, 32'h3, "mode locked");
    $display("test pwm done");
    give_verdict();
  end
endmodule // tb
